// *** hw/cthd_regs.vh ***
/*
 * Register offsets, field positions, reset values and arithmetic
 * constants of the current distortion monitor.
 * Assumes a byte-addressed plain register port of 8 address bits.
 */
`ifndef CTHD_REGS_VH
`define CTHD_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CTHD_ADDR_CTRL        8'h00
`define CTHD_ADDR_LIMIT_BASE  8'h10
`define CTHD_ADDR_DELAY_BASE  8'h30
`define CTHD_ADDR_STATUS      8'h40
`define CTHD_ADDR_CNT_START   8'h44
`define CTHD_ADDR_CNT_ALARM   8'h48
`define CTHD_ADDR_CNT_BLOCK   8'h4c
`define CTHD_ADDR_EVT_TIME    8'h50
`define CTHD_ADDR_EVT_CODE    8'h54

// ****************************************************************
// control fields
// ****************************************************************
`define CTHD_CTRL_MODE_LSB    0
`define CTHD_CTRL_MODSEL_BIT  3
`define CTHD_CTRL_POWER_BIT   4
`define CTHD_CTRL_EN_LSB      5
`define CTHD_CTRL_GROUP_BIT   8
`define CTHD_CTRL_RESET       9'h0e0

// ****************************************************************
// operating modes and element states
// ****************************************************************
`define CTHD_MODE_ON          3'h0
`define CTHD_MODE_BLOCKED     3'h1
`define CTHD_MODE_TEST        3'h2
`define CTHD_MODE_TEST_BLK    3'h3
`define CTHD_MODE_OFF         3'h4

`define CTHD_ST_NORMAL        2'h0
`define CTHD_ST_START         2'h1
`define CTHD_ST_ALARM         2'h2
`define CTHD_ST_BLOCKED       2'h3

// ****************************************************************
// limits in 0.01 % steps, delays in 5 ms steps
// ****************************************************************
`define CTHD_LIMIT_DEFAULT    14'h03e8
`define CTHD_LIMIT_MIN        14'h000a
`define CTHD_LIMIT_MAX        14'h2710
`define CTHD_DELAY_DEFAULT    19'h007d0
`define CTHD_DELAY_MAX        19'h57e40

// ****************************************************************
// ratio scaling: 100 x 10000 for power, 100 x 10000^2 for amplitude
// ****************************************************************
`define CTHD_POWER_SCALE      40'h00000f4240
`define CTHD_AMP_SCALE        40'h02540be400
`define CTHD_PICK_PCT         7'h64
// release level in 0.01 % of limit: 97 % (power), 97 % squared (amplitude)
`define CTHD_REL_POWER        14'h25e4
`define CTHD_REL_AMP          14'h24c1

`endif

// *** hw/cthd_monitor.v ***
/*
 * Current harmonic distortion monitor: accumulates five FFT spectra,
 * forms power or amplitude ratios, and runs three alarm elements.
 * Assumes the spectrum source and blocking input run on clock, and
 * that no spectrum sample arrives in the cycle of spec_done.
 */
// Our own choices: the address-and-strobe port and the placing of the registers.
// Notes on behaviour
// - harmonics one (fundamental) through 31 of every channel are used.
// - power ratio is sum of squares 2..31 over fundamental squared.
// - one shared control bit picks amplitude or power; amplitude default.
// - a control bit picks the first or second current module.
// - mode On, Blocked, Test, Test-blocked or Off; On after reset.
// - each element asserts start or alarm only while enabled.
// - phase element picks up when any phase ratio exceeds its limit.
// - each residual element has its own limit, default 10.00 %.
// - limits are kept between 0.10 % and 100.00 % in 0.01 % steps.
// - a picked channel releases below 97 % of its limit, fixed.
// - one phase limit serves all three phases, checked every frame.
// - limits come from the active group, switchable at run time.
// - a readable status shows Normal, Start, Alarm or Blocked.
// - blocking is sampled per frame; blocked at pick-up clears start.
// - per-element alarm delay 0 to 1800 s in 5 ms steps, 10 s default.
// - start, alarm and blocked events are counted and time-stamped.
`include "cthd_regs.vh"
`default_nettype none
module cthd_monitor #(
  parameter MAG_W = 16
) (
  input  wire              clock,
  input  wire              rstn,
  input  wire [7:0]        addr,
  input  wire [31:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [31:0]       rdata,
  input  wire              spec_valid,
  input  wire              spec_module,
  input  wire [2:0]        spec_channel,
  input  wire [4:0]        spec_index,
  input  wire [MAG_W-1:0]  spec_mag,
  input  wire              spec_done,
  input  wire              block_in,
  output reg  [2:0]        start_out,
  output reg  [2:0]        alarm_out,
  output reg               blocked_out
);

  localparam SQ_W  = 2 * MAG_W;
  localparam SUM_W = SQ_W + 5;
  localparam CMP_W = SUM_W + 40;
  localparam REL_W = CMP_W + 7;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function [13:0] clamp_limit;
    input [31:0] v;
    begin
      if (v < {18'h0, `CTHD_LIMIT_MIN})
        clamp_limit = `CTHD_LIMIT_MIN;
      else if (v > {18'h0, `CTHD_LIMIT_MAX})
        clamp_limit = `CTHD_LIMIT_MAX;
      else
        clamp_limit = v[13:0];
    end
  endfunction
  function [1:0] count3;
    input [2:0] v;
    begin
      count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    end
  endfunction
  // ****************************************************************
  // settings and state
  // ****************************************************************
  reg  [8:0]       ctrl;
  reg  [13:0]      limit [0:5];
  reg  [18:0]      delay [0:2];
  reg  [SUM_W-1:0] acc_sum [0:4];
  reg  [SQ_W-1:0]  acc_fund [0:4];
  reg  [4:0]       over;
  wire [4:0]       next_over;
  reg              blk_s;
  reg              eval;
  reg  [5:0]       state;
  reg  [56:0]      timer;
  reg  [15:0]      cnt_start;
  reg  [15:0]      cnt_alarm;
  reg  [15:0]      cnt_block;
  reg  [31:0]      stamp;
  reg  [31:0]      evt_time;
  reg  [8:0]       evt_code;
  reg  [5:0]       next_state;
  reg  [56:0]      next_timer;
  reg  [2:0]       ev_start;
  reg  [2:0]       ev_alarm;
  reg  [2:0]       ev_block;
  reg  [31:0]      next_rdata;

  wire [2:0]      mode   = ctrl[`CTHD_CTRL_MODE_LSB +: 3];
  wire            modsel = ctrl[`CTHD_CTRL_MODSEL_BIT];
  wire            power  = ctrl[`CTHD_CTRL_POWER_BIT];
  wire [2:0]      enable = ctrl[`CTHD_CTRL_EN_LSB +: 3];
  wire            group  = ctrl[`CTHD_CTRL_GROUP_BIT];
  wire            forced = (mode == `CTHD_MODE_BLOCKED) ||
                           (mode == `CTHD_MODE_TEST_BLK);
  wire            test   = (mode == `CTHD_MODE_TEST) ||
                           (mode == `CTHD_MODE_TEST_BLK);
  wire            running = (mode <= `CTHD_MODE_TEST_BLK);
  wire [SQ_W-1:0] sq     = spec_mag * spec_mag;
  wire            take   = spec_valid && (spec_module == modsel) &&
                           (spec_channel < 3'h5);
  wire            clr_cnt = wr && ((addr == `CTHD_ADDR_CNT_START) ||
                                   (addr == `CTHD_ADDR_CNT_ALARM) ||
                                   (addr == `CTHD_ADDR_CNT_BLOCK));
  wire [2:0]      elem_over = {over[4], over[3], |over[2:0]};
  integer i;
  // ****************************************************************
  // spectrum accumulation
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      for (i = 0; i < 5; i = i + 1) begin
        acc_sum[i]  <= {SUM_W{1'b0}};
        acc_fund[i] <= {SQ_W{1'b0}};
      end
      over  <= 5'h00;
      blk_s <= 1'b0;
      eval  <= 1'b0;
    end else begin
      eval <= spec_done;
      if (spec_done) begin
        over  <= next_over;
        blk_s <= block_in;
        for (i = 0; i < 5; i = i + 1) begin
          acc_sum[i]  <= {SUM_W{1'b0}};
          acc_fund[i] <= {SQ_W{1'b0}};
        end
      end else if (take) begin
        if (spec_index == 5'h01)
          acc_fund[spec_channel] <= sq;
        else if (spec_index >= 5'h02)
          acc_sum[spec_channel] <= acc_sum[spec_channel] +
                                   {5'h00, sq};
      end
    end
  end

  // ****************************************************************
  // ratio comparison per channel
  // ****************************************************************
  genvar c;
  generate
    for (c = 0; c < 5; c = c + 1) begin : g_ch
      localparam [2:0] E = (c == 3) ? 3'h1 : ((c == 4) ? 3'h2 : 3'h0);
      wire [2:0]       li  = E + (group ? 3'h3 : 3'h0);
      wire [13:0]      lim = limit[li];
      wire [27:0]      thr = power ? {14'h0000, lim} : lim * lim;
      wire [CMP_W-1:0] lhs = acc_sum[c] *
                             (power ? `CTHD_POWER_SCALE
                                    : `CTHD_AMP_SCALE);
      wire [CMP_W-1:0] rhs_pick = thr * acc_fund[c] * `CTHD_PICK_PCT;
      wire [REL_W-1:0] lhs_rel  = lhs * `CTHD_PICK_PCT;
      wire [REL_W-1:0] rhs_rel  = thr * acc_fund[c] *
                        (power ? `CTHD_REL_POWER : `CTHD_REL_AMP);
      assign next_over[c] = over[c] ? !(lhs_rel < rhs_rel)
                                    : (lhs > rhs_pick);
    end
  endgenerate
  // ****************************************************************
  // alarm elements
  // ****************************************************************
  always @* begin
    next_state = state;
    next_timer = timer;
    ev_start   = 3'h0;
    ev_alarm   = 3'h0;
    ev_block   = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (!running || !enable[i]) begin
        next_state[i*2 +: 2] = `CTHD_ST_NORMAL;
        next_timer[i*19 +: 19] = 19'h00000;
      end else if (eval) begin
        case (state[i*2 +: 2])
          `CTHD_ST_NORMAL: begin
            if (elem_over[i]) begin
              next_timer[i*19 +: 19] = 19'h00000;
              if (blk_s || forced) begin
                next_state[i*2 +: 2] = `CTHD_ST_BLOCKED;
                ev_block[i] = 1'b1;
              end else if (delay[i] == 19'h00000) begin
                next_state[i*2 +: 2] = `CTHD_ST_ALARM;
                ev_start[i] = 1'b1;
                ev_alarm[i] = 1'b1;
              end else begin
                next_state[i*2 +: 2] = `CTHD_ST_START;
                ev_start[i] = 1'b1;
              end
            end
          end
          `CTHD_ST_START: begin
            if (!elem_over[i])
              next_state[i*2 +: 2] = `CTHD_ST_NORMAL;
            else if (blk_s || forced) begin
              next_state[i*2 +: 2] = `CTHD_ST_BLOCKED;
              ev_block[i] = 1'b1;
            end else if (timer[i*19 +: 19] + 19'h00001 >= delay[i]) begin
              next_state[i*2 +: 2] = `CTHD_ST_ALARM;
              ev_alarm[i] = 1'b1;
            end else
              next_timer[i*19 +: 19] = timer[i*19 +: 19] + 19'h00001;
          end
          `CTHD_ST_ALARM: begin
            if (!elem_over[i])
              next_state[i*2 +: 2] = `CTHD_ST_NORMAL;
            else if (blk_s || forced) begin
              next_state[i*2 +: 2] = `CTHD_ST_BLOCKED;
              ev_block[i] = 1'b1;
            end
          end
          `CTHD_ST_BLOCKED: begin
            if (!elem_over[i])
              next_state[i*2 +: 2] = `CTHD_ST_NORMAL;
            else if (!blk_s && !forced) begin
              next_state[i*2 +: 2] = `CTHD_ST_START;
              next_timer[i*19 +: 19] = 19'h00000;
              ev_start[i] = 1'b1;
            end
          end
          default: next_state[i*2 +: 2] = `CTHD_ST_NORMAL;
        endcase
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      state       <= 6'h00;
      timer       <= 57'h0;
      start_out   <= 3'h0;
      alarm_out   <= 3'h0;
      blocked_out <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      for (i = 0; i < 3; i = i + 1) begin
        start_out[i] <= !test && enable[i] &&
                        ((state[i*2 +: 2] == `CTHD_ST_START) ||
                         (state[i*2 +: 2] == `CTHD_ST_ALARM));
        alarm_out[i] <= !test && enable[i] &&
                        (state[i*2 +: 2] == `CTHD_ST_ALARM);
      end
      blocked_out <= (state[1:0] == `CTHD_ST_BLOCKED) ||
                     (state[3:2] == `CTHD_ST_BLOCKED) ||
                     (state[5:4] == `CTHD_ST_BLOCKED);
    end
  end

  // ****************************************************************
  // event counters and time stamp
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      cnt_start <= 16'h0000;
      cnt_alarm <= 16'h0000;
      cnt_block <= 16'h0000;
      stamp     <= 32'h00000000;
      evt_time  <= 32'h00000000;
      evt_code  <= 9'h000;
    end else begin
      stamp <= stamp + 32'h00000001;
      cnt_start <= (clr_cnt ? 16'h0000 : cnt_start) +
                   {14'h0000, count3(ev_start)};
      cnt_alarm <= (clr_cnt ? 16'h0000 : cnt_alarm) +
                   {14'h0000, count3(ev_alarm)};
      cnt_block <= (clr_cnt ? 16'h0000 : cnt_block) +
                   {14'h0000, count3(ev_block)};
      if (|{ev_block, ev_alarm, ev_start}) begin
        evt_time <= stamp;
        evt_code <= {ev_block, ev_alarm, ev_start};
      end
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      ctrl <= `CTHD_CTRL_RESET;
      for (i = 0; i < 6; i = i + 1)
        limit[i] <= `CTHD_LIMIT_DEFAULT;
      for (i = 0; i < 3; i = i + 1)
        delay[i] <= `CTHD_DELAY_DEFAULT;
    end else if (wr) begin
      if (addr == `CTHD_ADDR_CTRL)
        ctrl <= wdata[8:0];
      for (i = 0; i < 6; i = i + 1)
        if (addr == `CTHD_ADDR_LIMIT_BASE + i[5:0] * 8'h04)
          limit[i] <= clamp_limit(wdata);
      for (i = 0; i < 3; i = i + 1)
        if (addr == `CTHD_ADDR_DELAY_BASE + i[5:0] * 8'h04)
          delay[i] <= (wdata > {13'h0000, `CTHD_DELAY_MAX}) ?
                      `CTHD_DELAY_MAX : wdata[18:0];
    end
  end
  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `CTHD_ADDR_CTRL:      next_rdata = {23'h000000, ctrl};
      `CTHD_ADDR_STATUS:    next_rdata = {25'h0000000, blocked_out,
                                          state};
      `CTHD_ADDR_CNT_START: next_rdata = {16'h0000, cnt_start};
      `CTHD_ADDR_CNT_ALARM: next_rdata = {16'h0000, cnt_alarm};
      `CTHD_ADDR_CNT_BLOCK: next_rdata = {16'h0000, cnt_block};
      `CTHD_ADDR_EVT_TIME:  next_rdata = evt_time;
      `CTHD_ADDR_EVT_CODE:  next_rdata = {23'h000000, evt_code};
      default: begin
        for (i = 0; i < 6; i = i + 1)
          if (addr == `CTHD_ADDR_LIMIT_BASE + i[5:0] * 8'h04)
            next_rdata = {18'h00000, limit[i]};
        for (i = 0; i < 3; i = i + 1)
          if (addr == `CTHD_ADDR_DELAY_BASE + i[5:0] * 8'h04)
            next_rdata = {13'h0000, delay[i]};
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rstn)
      rdata <= 32'h00000000;
    else
      rdata <= rd ? next_rdata : 32'h00000000;
  end
endmodule
`default_nettype wire

// *** tb/cthd_monitor_props.sv ***
/* port assertions of the distortion monitor.
   assumes one clock domain and rstn synchronous, active low. */
`include "cthd_regs.vh"
`default_nettype none
module cthd_monitor_props (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        spec_done,
  input wire logic [2:0]  start_out,
  input wire logic [2:0]  alarm_out,
  input wire logic        blocked_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // helper logic and properties
  // ****************************************************************
  logic [3:0] wr_hist;
  always_ff @(posedge clock) wr_hist <= {wr_hist[2:0], wr};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_cause;
    $past(spec_done, 3) || (wr_hist != 4'h0);
  endsequence
  property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
  property p_reset_quiet;
    disable iff (1'b0) !rstn |=> (start_out == 3'h0) &&
      (alarm_out == 3'h0) && !blocked_out && (rdata == 32'h0);
  endproperty
  property p_alarm_start; (alarm_out & ~start_out) == 3'h0; endproperty
  property p_start_cause; $changed(start_out) |-> s_cause; endproperty
  property p_alarm_cause; $changed(alarm_out) |-> s_cause; endproperty
  property p_blocked_cause; $changed(blocked_out) |-> s_cause; endproperty
  property p_status_blk;
    rd && (addr == `CTHD_ADDR_STATUS) |=> rdata[6] == $past(blocked_out);
  endproperty
  property p_unmapped; rd && (addr == 8'h60) |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero after idle cycle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  a_alarm_start: assert property (p_alarm_start)
    else $error("alarm without start");
  a_start_cause: assert property (p_start_cause)
    else $error("start changed without frame or write");
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm changed without frame or write");
  a_blocked_cause: assert property (p_blocked_cause)
    else $error("blocked changed without frame or write");
  a_status_blk: assert property (p_status_blk)
    else $error("status blocked bit differs from output");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule
bind cthd_monitor cthd_monitor_props i_props (
  .clock(clock), .rstn(rstn), .addr(addr), .wr(wr), .rd(rd),
  .rdata(rdata), .spec_done(spec_done), .start_out(start_out),
  .alarm_out(alarm_out), .blocked_out(blocked_out));
`default_nettype wire

// *** tb/cthd_fft_src.sv ***
/* fft spectrum source: five channels of 32 components, five samples of the other module, then done.
   assumes the bench sets levels and pulses go for one cycle. */
`default_nettype none
module cthd_fft_src (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic        sel,
  input  wire logic [79:0] fund,
  input  wire logic [79:0] harm,
  input  wire logic [4:0]  hidx,
  output logic             busy,
  output logic             spec_valid,
  output logic             spec_module,
  output logic [2:0]       spec_channel,
  output logic [4:0]       spec_index,
  output logic [15:0]      spec_mag,
  output logic             spec_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // ****************************************************************
  // sample stream
  // ****************************************************************
  function automatic logic [15:0] mag(input int k);
    if (k >= 160) return 16'hffff;
    if (k % 32 == 1) return fund[(k / 32) * 16 +: 16];
    if (k % 32 == hidx) return harm[(k / 32) * 16 +: 16];
    return (k % 32 == 0) ? 16'h5a5a : 16'h0000;
  endfunction
  initial begin
    {busy, spec_valid, spec_module, spec_channel} = '0;
    {spec_index, spec_mag, spec_done} = '0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy <= 1'b1;
        for (n = 0; n < 165; n++) begin
          spec_valid   <= 1'b1;
          spec_module  <= (n < 160) ? sel : ~sel;
          spec_channel <= (n < 160) ? 3'(n / 32) : 3'(n - 160);
          spec_index   <= (n < 160) ? 5'(n % 32) : 5'h02;
          spec_mag     <= mag(n);
          @(posedge clock);
        end
        spec_valid <= 1'b0;
        spec_mag   <= ~spec_mag;
        spec_done  <= 1'b1;
        @(posedge clock);
        spec_done <= 1'b0;
        busy      <= 1'b0;
      end else begin
        spec_mag <= ~spec_mag;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/cthd_monitor_tb.sv ***
/* self-checking bench of the distortion monitor.
   assumes the fft source model and the bound checker. */
`default_nettype none
module cthd_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rstn, wr, rd, go, sel, block_in, spec_valid, p, pk;
  logic        spec_module, spec_done, busy, blocked_out;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [79:0] fund, harm;
  logic [4:0]  hidx, spec_index;
  logic [2:0]  spec_channel, start_out, alarm_out;
  logic [15:0] spec_mag;
  int          n_fail, n_checks, cyc, i, f, h;
  logic [7:0]  ra [10] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30,
                           8'h34, 8'h38, 8'h40, 8'h60};
  logic [11:0] rv [10] = '{12'h0e0, 12'h3e8, 12'h3e8, 12'h3e8, 12'h3e8,
                           12'h7d0, 12'h7d0, 12'h7d0, 12'h000, 12'h000};
  int          ht [3] = '{317, 312, 311};
  cthd_monitor i_dut (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .spec_valid(spec_valid), .spec_module(spec_module),
    .spec_channel(spec_channel), .spec_index(spec_index),
    .spec_mag(spec_mag), .spec_done(spec_done), .block_in(block_in),
    .start_out(start_out), .alarm_out(alarm_out),
    .blocked_out(blocked_out));
  cthd_fft_src i_src (.clock(clock), .go(go), .sel(sel), .fund(fund),
    .harm(harm), .hidx(hidx), .busy(busy), .spec_valid(spec_valid),
    .spec_module(spec_module), .spec_channel(spec_channel),
    .spec_index(spec_index), .spec_mag(spec_mag), .spec_done(spec_done));
  // ****************************************************************
  // tasks and expectations
  // ****************************************************************
  function automatic logic pick(input longint f, h, l, input logic pw,
                                input logic prev);
    longint s, t;
    s = pw ? 64'd10000 : 64'd100000000;
    t = pw ? l : l * l;
    return prev ? !(10000 * h * h * s < (pw ? 9700 : 9409) * t * f * f)
                : (100 * h * h * s > 100 * t * f * f);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rreg(input logic [7:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  task automatic frame(input logic [2:0] s, a, input logic b);
    int k;
    hidx <= 5'(2 + $urandom % 30);
    go   <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clock);
    repeat (3) @(posedge clock);
    chk("start_out", {29'h0, s}, {29'h0, start_out});
    chk("alarm_out", {29'h0, a}, {29'h0, alarm_out});
    chk("blocked_out", {31'h0, b}, {31'h0, blocked_out});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************************************************************
  // clock, timeout and test sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    {rstn, wr, rd, go, sel, block_in, addr, wdata, hidx} = '0;
    {n_fail, n_checks, cyc} = '0;
    fund = {5{16'd1000}};
    harm = '0;
    void'($urandom(27195));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 10; i++) begin
      rreg(ra[i]);
      chk("register", {20'h0, rv[i]}, v);
    end
    wreg(8'h10, 32'd5);
    rreg(8'h10);
    chk("limit_low", 32'h0000000a, v);
    wreg(8'h10, 32'd20000);
    rreg(8'h10);
    chk("limit_high", 32'h00002710, v);
    wreg(8'h10, 32'd1000);
    $display("test registers done");
    wreg(8'h30, 32'd2);
    harm[31:16] <= 16'd100;
    frame(3'h0, 3'h0, 1'b0);
    harm[31:16] <= 16'd101;
    frame(3'h1, 3'h0, 1'b0);
    frame(3'h1, 3'h0, 1'b0);
    frame(3'h1, 3'h1, 1'b0);
    rreg(8'h40);
    chk("status", 32'h00000002, v);
    harm[63:48] <= 16'd101;
    frame(3'h3, 3'h1, 1'b0);
    wreg(8'h00, 32'h0c0);
    frame(3'h2, 3'h0, 1'b0);
    wreg(8'h00, 32'h0e0);
    frame(3'h3, 3'h0, 1'b0);
    $display("test amplitude done");
    for (i = 3; i >= 0; i--) begin
      wreg(8'h00, 32'h0e4);
      frame(3'h0, 3'h0, 1'b0);
      wreg(8'h00, 32'h0e0 | 32'(i));
      frame((i == 0) ? 3'h3 : 3'h0, 3'h0, i[0]);
    end
    block_in <= 1'b1;
    wreg(8'h00, 32'h0e4);
    wreg(8'h00, 32'h0e0);
    frame(3'h0, 3'h0, 1'b1);
    block_in <= 1'b0;
    frame(3'h3, 3'h0, 1'b0);
    wreg(8'h1c, 32'd2000);
    wreg(8'h00, 32'h1e0);
    frame(3'h2, 3'h0, 1'b0);
    wreg(8'h00, 32'h0e0);
    frame(3'h3, 3'h0, 1'b0);
    $display("test modes done");
    harm <= '0;
    sel  <= 1'b1;
    wreg(8'h00, 32'h0f8);
    frame(3'h0, 3'h0, 1'b0);
    for (i = 0; i < 3; i++) begin
      harm[63:48] <= 16'(ht[i]);
      frame((i < 2) ? 3'h2 : 3'h0, 3'h0, 1'b0);
    end
    harm <= '0;
    sel  <= 1'b0;
    pk = 1'b0;
    for (i = 0; i < 20; i++) begin
      f = 500 + $urandom % 1000;
      h = $urandom % 300;
      p = 1'($urandom % 2);
      wreg(8'h00, 32'h0e0 | (32'(p) << 4));
      fund[79:64] <= 16'(f);
      harm[79:64] <= 16'(h);
      pk = pick(f, h, 1000, p, pk);
      frame({pk, 2'b00}, 3'h0, 1'b0);
    end
    $display("test random done");
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rreg(8'h00);
    chk("ctrl_reset", 32'h000000e0, v);
    $display("test reset done");
    harm <= 80'h0000_0000_0000_0065_0000;
    frame(3'h1, 3'h0, 1'b0);
    rreg(8'h44);
    chk("cnt_start", 32'h00000001, v);
    rreg(8'h54);
    chk("evt_code", 32'h00000001, v);
    wreg(8'h48, 32'h0);
    rreg(8'h44);
    chk("cnt_clear", 32'h00000000, v);
    $display("test counters done");
    complete_run();
  end
endmodule
`default_nettype wire
